// *** src/bpan_ctrl.sv ***
// Purpose: negotiation control, nonce and random bit generation, next-page handshake
// Assumes: apb slave, link page words arrive as single-cycle strobes on i_clk_sys
// Notes: one wait state on every apb access; unmapped addresses answer pslverr

// Overview of operation
// RULE_01: negotiate only while enable bit set
// RULE_02: bypass stops negotiation, connects pcs anyway
// RULE_03: eight-bit seed initialises nonce generator
// RULE_04: polynomial select picks random bit taps
// RULE_05: restart returns negotiation to start always; the code ignores restart while bypass is set or enable is clear
// RULE_06: local fault copied into codeword
// RULE_07: pause advert drives codeword bit c0
// RULE_08: asymmetric advert drives codeword bit c1
// RULE_09: local next page request sends local word
// RULE_10: no next page initiation without request
// RULE_11: partner pages answered by null pages
// RULE_12: host acknowledges only after reading page
// RULE_13: acknowledge sends ack and next codeword
// RULE_14: partner valid drops until new page
// RULE_15: ability bits advertised in base page
// RULE_16: link control codes 00,01,11 used
// RULE_17: everything synchronous to one clock
module bpan_ctrl import bpan_pkg::*; #(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic i_rx_page_valid,
	input wire logic [47:0] i_rx_page,
	output logic [47:0] o_tx_page,
	output logic o_random_bit,
	output logic [2*BPAN_NUM_TECH-1:0] o_link_control
);
	logic [6:0] ctrl_r;
	logic [7:0] seed_r;
	logic [BPAN_NUM_TECH-1:0] ability_r;
	logic [47:0] local_word_r;
	logic [47:0] partner_word_r;
	logic [47:0] partner_base_r;
	logic partner_valid_r;
	logic ack_r;
	logic local_np_sent_r;
	logic complete_r;
	logic [7:0] nonce_r;
	logic [6:0] rand_r;
	logic [3:0] tech_r;
	bpan_state_t state_r;
	bpan_state_t state_nxt;
	logic [47:0] tx_nxt;
	logic [31:0] rdata_nxt;
	logic map_hit;
	logic wr_acc;
	logic rd_acc;
	logic restart_evt;
	logic host_ack_evt;
	logic rand_fb;
	logic fresh_start;

	// control field shorthands
	logic an_en;
	logic an_byp;
	logic lnp_req;
	assign an_en = ctrl_r[BPAN_CTL_EN];
	assign an_byp = ctrl_r[BPAN_CTL_BYP];
	assign lnp_req = ctrl_r[BPAN_CTL_LNP];

	// address decode used by write qualifier and error answer
	function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = a[7:0];
		addr_mapped = (b[1:0] == 2'h0) && (b <= BPAN_OFS_TX_HI);
	endfunction

	// highest common technology between both ends
	function automatic logic [3:0] pick_tech(input logic [BPAN_NUM_TECH-1:0] common);
		pick_tech = 4'hF;
		for (int k = 0; k < BPAN_NUM_TECH; k++) begin
			if (common[k]) begin
				pick_tech = 4'(k);
			end
		end
	endfunction

	// apb access qualifiers, acted on in the wait-state cycle before pready
	assign map_hit = addr_mapped(i_paddr);
	assign wr_acc = i_psel && i_penable && !o_pready && i_pwrite && map_hit;
	assign rd_acc = i_psel && i_penable && !o_pready && !i_pwrite;
	assign restart_evt = wr_acc && (i_paddr[7:0] == BPAN_OFS_CTRL)
		&& i_pwdata[BPAN_CTL_RESTART];
	assign host_ack_evt = wr_acc && (i_paddr[7:0] == BPAN_OFS_STAT)
		&& i_pwdata[BPAN_STAT_ACK]; // RULE_12

	// apb handshake: one wait state, error on unmapped address
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_pready <= 1'b0;
			o_pslverr <= 1'b0;
			o_prdata <= 32'h0000_0000;
		end else begin
			o_pready <= i_psel && i_penable && !o_pready;
			o_pslverr <= i_psel && i_penable && !o_pready && !map_hit;
			o_prdata <= rd_acc ? rdata_nxt : 32'h0000_0000;
		end
	end

	// software-written configuration
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			ctrl_r <= BPAN_CTRL_RST;
			seed_r <= BPAN_SEED_RST;
			ability_r <= '0;
			local_word_r <= '0;
		end else if (wr_acc) begin // RULE_17
			unique case (i_paddr[7:0])
				BPAN_OFS_CTRL: ctrl_r <= i_pwdata[6:0];
				BPAN_OFS_SEED: seed_r <= i_pwdata[7:0];
				BPAN_OFS_ABIL: ability_r <= i_pwdata[BPAN_NUM_TECH-1:0];
				BPAN_OFS_LNP_LO: local_word_r[31:0] <= i_pwdata;
				BPAN_OFS_LNP_HI: local_word_r[47:32] <= i_pwdata[15:0];
				default: ;
			endcase
		end
	end

	// read mux
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		unique case (i_paddr[7:0])
			BPAN_OFS_CTRL: rdata_nxt = {25'h000_0000, ctrl_r};
			BPAN_OFS_SEED: rdata_nxt = {24'h00_0000, seed_r};
			BPAN_OFS_ABIL: rdata_nxt = {17'h0_0000, ability_r};
			BPAN_OFS_LNP_LO: rdata_nxt = local_word_r[31:0];
			BPAN_OFS_LNP_HI: rdata_nxt = {16'h0000, local_word_r[47:32]};
			BPAN_OFS_PNP_LO: rdata_nxt = partner_word_r[31:0];
			BPAN_OFS_PNP_HI: rdata_nxt = {16'h0000, partner_word_r[47:32]};
			BPAN_OFS_STAT: rdata_nxt = {27'h000_0000, complete_r, partner_valid_r, state_r};
			BPAN_OFS_LCTL: rdata_nxt = {2'h0, o_link_control};
			BPAN_OFS_TX_LO: rdata_nxt = o_tx_page[31:0];
			BPAN_OFS_TX_HI: rdata_nxt = {16'h0000, o_tx_page[47:32]};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end

	// negotiation sequencing
	always_comb begin
		state_nxt = state_r;
		if (an_byp) begin
			state_nxt = BPAN_BYPASS; // RULE_02
		end else if (!an_en) begin
			state_nxt = BPAN_OFF; // RULE_01
		end else if (restart_evt || state_r == BPAN_OFF || state_r == BPAN_BYPASS) begin
			state_nxt = BPAN_BASE; // RULE_05
		end else begin
			unique case (state_r)
				BPAN_BASE: begin
					if (i_rx_page_valid) begin
						state_nxt = (lnp_req || i_rx_page[BPAN_CW_NP]) ? BPAN_NP_WAIT : BPAN_GOOD;
					end
				end
				BPAN_NP_WAIT: begin
					if (i_rx_page_valid) begin
						state_nxt = BPAN_NP_HOLD;
					end
				end
				BPAN_NP_HOLD: begin
					if (host_ack_evt) begin
						state_nxt = (partner_word_r[BPAN_CW_NP] || local_np_sent_r)
							? BPAN_NP_WAIT : BPAN_GOOD;
					end
				end
				BPAN_GOOD: state_nxt = BPAN_GOOD;
				default: state_nxt = BPAN_OFF;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			state_r <= BPAN_OFF;
		end else begin
			state_r <= state_nxt; // RULE_17
		end
	end

	// fresh start: entry to the base page, or a restart while already there
	assign fresh_start = state_nxt == BPAN_BASE && (state_r != BPAN_BASE || restart_evt); // RULE_05

	// partner pages and next-page handshake flags
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			partner_base_r <= '0;
			partner_word_r <= '0;
			partner_valid_r <= 1'b0;
			ack_r <= 1'b0;
			local_np_sent_r <= 1'b0;
		end else if (fresh_start) begin
			partner_valid_r <= 1'b0;
			ack_r <= 1'b0;
			local_np_sent_r <= 1'b0;
		end else begin
			if (state_r == BPAN_BASE && i_rx_page_valid) begin
				partner_base_r <= i_rx_page;
				ack_r <= 1'b1;
				local_np_sent_r <= lnp_req; // RULE_10
			end
			if (state_r == BPAN_NP_WAIT && i_rx_page_valid) begin
				partner_word_r <= i_rx_page;
				partner_valid_r <= 1'b1;
				ack_r <= 1'b0;
			end else if (state_r == BPAN_NP_HOLD && host_ack_evt) begin
				partner_valid_r <= 1'b0; // RULE_14
				ack_r <= 1'b1; // RULE_13
				local_np_sent_r <= lnp_req;
			end
		end
	end

	// nonce generator seeded on every fresh start
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			nonce_r <= BPAN_SEED_RST;
		end else if (fresh_start) begin
			nonce_r <= seed_r; // RULE_03
		end else begin
			nonce_r <= {nonce_r[6:0], nonce_r[7] ^ nonce_r[5] ^ nonce_r[4] ^ nonce_r[3]};
		end
	end

	// random bit generator with selectable polynomial
	assign rand_fb = ctrl_r[BPAN_CTL_PSEL] ? (rand_r[6] ^ rand_r[5]) : (rand_r[6] ^ rand_r[2]);
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			rand_r <= 7'h01;
			o_random_bit <= 1'b0;
		end else begin
			if (fresh_start) begin
				rand_r <= seed_r[6:0] | 7'h01;
			end else begin
				rand_r <= {rand_r[5:0], rand_fb}; // RULE_04
			end
			o_random_bit <= rand_r[6];
		end
	end

	// transmitted codeword
	always_comb begin
		tx_nxt = '0;
		if (state_r == BPAN_BASE || state_r == BPAN_GOOD) begin
			tx_nxt[4:0] = BPAN_SELECTOR;
			tx_nxt[BPAN_CW_PAUSE] = ctrl_r[BPAN_CTL_PAUSE]; // RULE_07
			tx_nxt[BPAN_CW_ASM] = ctrl_r[BPAN_CTL_ASM]; // RULE_08
			tx_nxt[BPAN_CW_FLT] = ctrl_r[BPAN_CTL_FLT]; // RULE_06
			tx_nxt[BPAN_CW_NP] = lnp_req; // RULE_10
			tx_nxt[BPAN_CW_NONCE +: 5] = nonce_r[4:0];
			tx_nxt[BPAN_CW_ABIL +: BPAN_NUM_TECH] = ability_r; // RULE_15
		end else if (state_r == BPAN_NP_WAIT || state_r == BPAN_NP_HOLD) begin
			tx_nxt = local_np_sent_r ? local_word_r : BPAN_NULL_PAGE; // RULE_09 RULE_11
		end
		tx_nxt[BPAN_CW_ACK] = ack_r && state_r != BPAN_OFF && state_r != BPAN_BYPASS;
	end

	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			o_tx_page <= '0;
		end else begin
			o_tx_page <= tx_nxt;
		end
	end

	// resolved technology and per-technology link control
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			tech_r <= 4'hF;
			complete_r <= 1'b0;
		end else begin
			tech_r <= pick_tech(ability_r & partner_base_r[BPAN_CW_ABIL +: BPAN_NUM_TECH]);
			complete_r <= state_r == BPAN_GOOD;
		end
	end

	genvar g;
	generate
		for (g = 0; g < BPAN_NUM_TECH; g++) begin : g_lc
			always_ff @(posedge i_clk_sys or posedge i_rst) begin
				if (i_rst) begin
					o_link_control[2*g +: 2] <= BPAN_LC_DISABLE;
				end else if (state_r == BPAN_BYPASS) begin
					o_link_control[2*g +: 2] <= ability_r[g] ? BPAN_LC_ENABLE : BPAN_LC_DISABLE;
				end else if (state_r == BPAN_GOOD) begin
					o_link_control[2*g +: 2] <= (tech_r == 4'(g)) ? BPAN_LC_ENABLE
						: BPAN_LC_DISABLE; // RULE_16
				end else if (state_r == BPAN_OFF) begin
					o_link_control[2*g +: 2] <= BPAN_LC_DISABLE;
				end else begin
					o_link_control[2*g +: 2] <= ability_r[g] ? BPAN_LC_SCAN : BPAN_LC_DISABLE;
				end
			end
		end
	endgenerate

	// checks
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sequence s_host_ack;
		state_r == BPAN_NP_HOLD && host_ack_evt;
	endsequence
	sequence s_page_released;
		!partner_valid_r && ack_r;
	endsequence

	a_disabled_off: assert property (!an_en && !an_byp |=> state_r == BPAN_OFF) // RULE_01
		else $error("negotiation ran while disabled");
	a_bypass_enable: assert property (an_byp |=> state_r == BPAN_BYPASS ##1 // RULE_02
		o_link_control[1:0] == ($past(ability_r[0]) ? BPAN_LC_ENABLE : BPAN_LC_DISABLE))
		else $error("bypass did not connect pcs");
	a_seed_loaded: assert property (state_r == BPAN_OFF && state_nxt == BPAN_BASE // RULE_03
		|=> nonce_r == $past(seed_r))
		else $error("nonce not seeded");
	a_poly_taps: assert property (!fresh_start |=> rand_r[0] == // RULE_04
		($past(ctrl_r[BPAN_CTL_PSEL]) ? ($past(rand_r[6]) ^ $past(rand_r[5]))
		: ($past(rand_r[6]) ^ $past(rand_r[2]))))
		else $error("random bit polynomial wrong");
	a_restart_base: assert property (restart_evt && an_en && !an_byp // RULE_05 RULE_03
		|=> state_r == BPAN_BASE && nonce_r == $past(seed_r))
		else $error("restart ignored");
	a_fault_bit: assert property (state_r == BPAN_BASE // RULE_06
		|=> o_tx_page[BPAN_CW_FLT] == $past(ctrl_r[BPAN_CTL_FLT]))
		else $error("fault bit wrong");
	a_pause_bits: assert property (state_r == BPAN_BASE |=> // RULE_07 RULE_08
		o_tx_page[BPAN_CW_PAUSE] == $past(ctrl_r[BPAN_CTL_PAUSE])
		&& o_tx_page[BPAN_CW_ASM] == $past(ctrl_r[BPAN_CTL_ASM]))
		else $error("pause advert bits wrong");
	a_np_content: assert property (state_r == BPAN_NP_WAIT |=> // RULE_09 RULE_11
		o_tx_page[13:0] == ($past(local_np_sent_r) ? $past(local_word_r[13:0])
		: BPAN_NULL_PAGE[13:0]))
		else $error("next page content wrong");
	a_ack_release: assert property (s_host_ack |=> s_page_released ##1 // RULE_13 RULE_14
		o_tx_page[BPAN_CW_ACK])
		else $error("host ack not handled");
	a_lc_codes: assert property (o_link_control[1:0] != 2'h2) // RULE_16
		else $error("unused link control code");
endmodule

// *** src/bpan_pkg.sv ***
// Purpose: shared constants for the backplane negotiation control block
// Assumes: 32-bit apb data, one aligned word per register
// Notes: codeword bit positions follow the 48-bit link codeword layout
package bpan_pkg;
	// register byte offsets
	localparam logic [7:0] BPAN_OFS_CTRL = 8'h00;
	localparam logic [7:0] BPAN_OFS_SEED = 8'h04;
	localparam logic [7:0] BPAN_OFS_ABIL = 8'h08;
	localparam logic [7:0] BPAN_OFS_LNP_LO = 8'h0C;
	localparam logic [7:0] BPAN_OFS_LNP_HI = 8'h10;
	localparam logic [7:0] BPAN_OFS_PNP_LO = 8'h14;
	localparam logic [7:0] BPAN_OFS_PNP_HI = 8'h18;
	localparam logic [7:0] BPAN_OFS_STAT = 8'h1C;
	localparam logic [7:0] BPAN_OFS_LCTL = 8'h20;
	localparam logic [7:0] BPAN_OFS_TX_LO = 8'h24;
	localparam logic [7:0] BPAN_OFS_TX_HI = 8'h28;
	// control and status register fields
	localparam int BPAN_CTL_EN = 0;
	localparam int BPAN_CTL_BYP = 1;
	localparam int BPAN_CTL_PSEL = 2;
	localparam int BPAN_CTL_FLT = 3;
	localparam int BPAN_CTL_PAUSE = 4;
	localparam int BPAN_CTL_ASM = 5;
	localparam int BPAN_CTL_LNP = 6;
	localparam int BPAN_CTL_RESTART = 8;
	localparam int BPAN_STAT_ACK = 8;
	// reset values
	localparam logic [6:0] BPAN_CTRL_RST = 7'h00;
	localparam logic [7:0] BPAN_SEED_RST = 8'h00;
	// codeword fields
	localparam int BPAN_CW_PAUSE = 10;
	localparam int BPAN_CW_ASM = 11;
	localparam int BPAN_CW_FLT = 13;
	localparam int BPAN_CW_ACK = 14;
	localparam int BPAN_CW_NP = 15;
	localparam int BPAN_CW_NONCE = 16;
	localparam int BPAN_CW_ABIL = 21;
	localparam int BPAN_NUM_TECH = 15;
	localparam logic [4:0] BPAN_SELECTOR = 5'h01;
	localparam logic [47:0] BPAN_NULL_PAGE = 48'h0000_0000_0001;
	// link control codes
	localparam logic [1:0] BPAN_LC_DISABLE = 2'h0;
	localparam logic [1:0] BPAN_LC_SCAN = 2'h1;
	localparam logic [1:0] BPAN_LC_ENABLE = 2'h3;
	// negotiation states
	typedef enum logic [2:0] {
		BPAN_OFF = 3'b000,
		BPAN_BASE = 3'b001,
		BPAN_NP_WAIT = 3'b010,
		BPAN_NP_HOLD = 3'b011,
		BPAN_GOOD = 3'b100,
		BPAN_BYPASS = 3'b101
	} bpan_state_t;
endpackage

// *** tb/bpan_ctrl_tb.sv ***
// Purpose: self-checking bench for the negotiation control block
// Assumes: apb answers after one wait state, partner pages are strobes
// Notes: random bits are compared between runs, the nonce against the seed
module bpan_ctrl_tb import bpan_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, rx_valid, random_bit, er;
	logic send = 1'b0;
	logic [3:0] delay = 4'h0;
	logic [47:0] word = 48'h0000_0000_0000;
	logic [47:0] rx_page, tx_page;
	logic [29:0] link_control;
	logic [31:0] rd;
	int err_count = 0;
	int total_checks = 0;
	// free-running system clock
	always #25 clk_sys = ~clk_sys;
	bpan_ctrl uut (.i_clk_sys(clk_sys), .i_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_rx_page_valid(rx_valid),
		.i_rx_page(rx_page), .o_tx_page(tx_page), .o_random_bit(random_bit),
		.o_link_control(link_control));
	bpan_partner peer (.i_clk_sys(clk_sys), .i_rst(rst), .i_send(send), .i_delay(delay),
		.i_word(word), .o_valid(rx_valid), .o_page(rx_page));
	task automatic close_out();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge clk_sys);
			n++;
		end
		chk(pready, 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// asks the partner for one page and lets the answer settle
	task automatic page(input logic [47:0] w, input logic [3:0] dl);
		int n;
		n = 0;
		@(posedge clk_sys);
		send <= 1'b1;
		word <= w;
		delay <= dl;
		@(posedge clk_sys);
		send <= 1'b0;
		while (rx_valid !== 1'b1 && n < 40) begin
			@(posedge clk_sys);
			n++;
		end
		repeat (3) @(posedge clk_sys);
	endtask
	function automatic logic [47:0] bp(input logic [14:0] ab, input logic np);
		return {12'h000, ab, 5'h00, np, 10'h000, BPAN_SELECTOR};
	endfunction
	// reset values, unmapped access, pages ignored while disabled
	task automatic t_reset();
		apb(1'b0, BPAN_OFS_CTRL, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		apb(1'b0, 8'h2C, 32'h0000_0000);
		chk({er, rd}, {1'b1, 32'h0000_0000});
		page(bp(15'h7FFF, 1'b1), 4'h2);
		chk(link_control, 30'h0000_0000);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[2:0], 3'h0);
	endtask
	// bypass wins over enable and connects advertised technologies
	task automatic t_bypass();
		apb(1'b1, BPAN_OFS_ABIL, 32'h0000_0005);
		apb(1'b1, BPAN_OFS_CTRL, 32'h0000_0003);
		repeat (2) @(posedge clk_sys);
		chk(link_control, 30'h0000_0033);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[2:0], 3'h5);
	endtask
	// every fault, pause and direction combination in the base page
	task automatic t_base();
		logic [47:0] e;
		logic [47:0] s;
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, BPAN_OFS_CTRL, 32'h0000_0101 | 32'(i << 3));
			repeat (3) @(posedge clk_sys);
			e = {15'h0005, 1'b0, i[0], i[2], i[1], BPAN_SELECTOR};
			s = {tx_page[35:21], tx_page[15], tx_page[13], tx_page[11:10], tx_page[4:0]};
			chk(s, e);
		end
		chk(link_control, 30'h0000_0011);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[2:0], 3'h1);
	endtask
	// partner next pages answered with null pages, host acknowledges each
	task automatic t_np_null();
		page(bp(15'h0007, 1'b1), 4'h0);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[2:0], 3'h2);
		chk(tx_page, BPAN_NULL_PAGE | 48'h0000_0000_4000);
		page(48'hABCD_1234_8001, 4'h5);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[3:0], 4'hB);
		chk(tx_page[14], 1'b0);
		apb(1'b0, BPAN_OFS_PNP_LO, 32'h0000_0000);
		chk(rd, 32'h1234_8001);
		apb(1'b0, BPAN_OFS_PNP_HI, 32'h0000_0000);
		chk(rd, 32'h0000_ABCD);
		apb(1'b1, BPAN_OFS_STAT, 32'h0000_0100);
		repeat (2) @(posedge clk_sys);
		chk(tx_page[14], 1'b1);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[3:0], 4'h2);
		page(48'h0000_5555_0001, 4'h0);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[3:0], 4'hB);
		apb(1'b1, BPAN_OFS_STAT, 32'h0000_0100);
		repeat (2) @(posedge clk_sys);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[4:0], 5'h14);
		chk(link_control, 30'h0000_0030);
	endtask
	// local next page is sent, then a restart returns to the base page
	task automatic t_np_local();
		apb(1'b1, BPAN_OFS_LNP_LO, 32'h1234_0203);
		apb(1'b1, BPAN_OFS_LNP_HI, 32'h0000_00AB);
		apb(1'b1, BPAN_OFS_CTRL, 32'h0000_0141);
		repeat (3) @(posedge clk_sys);
		chk(tx_page[15], 1'b1);
		page(bp(15'h0001, 1'b0), 4'h0);
		chk(tx_page, 48'h00AB_1234_4203);
		apb(1'b1, BPAN_OFS_CTRL, 32'h0000_0141);
		repeat (2) @(posedge clk_sys);
		apb(1'b0, BPAN_OFS_STAT, 32'h0000_0000);
		chk(rd[2:0], 3'h1);
	endtask
	// polynomials differ from one seed, a restart reloads the seed, a new seed differs
	task automatic t_random();
		logic [15:0] s[4];
		logic [4:0] nc[4];
		apb(1'b1, BPAN_OFS_SEED, 32'h0000_005A);
		for (int k = 0; k < 4; k++) begin
			if (k == 3) begin
				apb(1'b1, BPAN_OFS_SEED, 32'h0000_00A5);
			end
			apb(1'b1, BPAN_OFS_CTRL, 32'h0000_0101 | 32'((k & 1) << 2));
			s[k] = 16'h0000;
			for (int b = 0; b < 16; b++) begin
				@(posedge clk_sys);
				if (b == 0) begin
					nc[k] = tx_page[20:16];
				end
				s[k] = {s[k][14:0], random_bit};
			end
		end
		chk(s[0] == s[1], 1'b0);
		chk(s[2], s[0]);
		chk(s[3] == s[0], 1'b0);
		chk({nc[0], nc[2], nc[3]}, {5'h1A, 5'h1A, 5'h05});
	endtask
	// main sequence
	initial begin
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		t_reset();
		t_bypass();
		t_base();
		t_np_null();
		t_np_local();
		t_random();
		close_out();
	end
	// watchdog against a hang
	initial begin
		#200000;
		err_count++;
		close_out();
	end
endmodule

// *** tb/bpan_partner.sv ***
// Purpose: remote link partner that sends pages to the negotiation block
// Assumes: each page is a one-cycle strobe on the system clock
// Notes: between strobes the page lines toggle so a stale page never looks valid
module bpan_partner (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_send,
	input wire logic [3:0] i_delay,
	input wire logic [47:0] i_word,
	output logic o_valid,
	output logic [47:0] o_page
);
	timeunit 1ns;
	timeprecision 1ns;
	logic pend_r;
	logic [3:0] wait_r;
	logic [47:0] word_r;
	// waits the requested number of cycles, then strobes the page once
	always_ff @(posedge i_clk_sys or posedge i_rst) begin
		if (i_rst) begin
			pend_r <= 1'b0;
			wait_r <= 4'h0;
			word_r <= 48'h0000_0000_0000;
			o_valid <= 1'b0;
			o_page <= 48'h0000_0000_0000;
		end else begin
			o_valid <= 1'b0;
			o_page <= ~o_page; // held value has run out
			if (i_send) begin
				pend_r <= 1'b1;
				wait_r <= i_delay;
				word_r <= i_word;
			end else if (pend_r && wait_r != 4'h0) begin
				wait_r <= wait_r - 4'h1;
			end else if (pend_r) begin
				pend_r <= 1'b0;
				o_valid <= 1'b1;
				o_page <= word_r;
			end
		end
	end
endmodule
